// ===== src/vcfc_defines.vh
// Constants of the video clamp and shaping filter configuration block.
// Assumes a 100 MHz core clock and an Avalon-MM slave with byte addresses.
//
// Contract
// - Revision identifier is read-only, writes ignored.
// - Override bit forces sync and field drivers active.
// - Fine clamp code gives 16/32/64/128 cycles.
// - Fast clamp code gives 16/32/64/128 cycles.
// - Current clamp enable switches current sources.
// - Voltage clamp enable switches voltage clamp.
// - Twelve-bit offset split high nibble, low byte.
// - Mode bit selects automatic or manual offset.
// - Manual offset applies to chroma only.
// - Freeze bit holds the clamp loop correction.
// - Timing field sets loop time constant.
// - Luma codes select notch and S-video filters.
// - Upper luma codes select NTSC notches, S-video 18.
// - Chroma field selects auto or fixed low-pass.
// - Auto chroma choice follows the scaling factor.
// - Decoder status register is read-only.
// - Status bits: lock, sticky lost lock, flags.
`ifndef VCFC_DEFINES_VH
`define VCFC_DEFINES_VH

// Register indices; the byte address is four times the index.
`define VCFC_IDX_STATUS 6'h10
`define VCFC_IDX_REVISION 6'h11
`define VCFC_IDX_TIMING 6'h13
`define VCFC_IDX_ACLAMP 6'h14
`define VCFC_IDX_DCLAMP_HI 6'h15
`define VCFC_IDX_DCLAMP_LO 6'h16
`define VCFC_IDX_FILTER 6'h17
`define VCFC_IDX_IRQ_STATUS 6'h20
`define VCFC_IDX_IRQ_ENABLE 6'h21
`define VCFC_IDX_IRQ_CLEAR 6'h22

// Reset values.
`define VCFC_RST_TIMING 8'h45
`define VCFC_RST_ACLAMP 8'h00
`define VCFC_RST_DCLAMP_HI 8'h00
`define VCFC_RST_DCLAMP_LO 8'h00
`define VCFC_RST_FILTER 8'h00

// Field positions.
`define VCFC_TIM_FORCE_BIT 1
`define VCFC_ACL_MASK 8'h3f
`define VCFC_ACL_CCL_BIT 4
`define VCFC_ACL_VCL_BIT 5
`define VCFC_DCH_OFS_MSB 3
`define VCFC_DCH_FREEZE_BIT 4
`define VCFC_DCH_TC_LSB 5
`define VCFC_DCH_MODE_BIT 7
`define VCFC_FLT_CHROMA_LSB 5

// Codes.
`define VCFC_LUMA_UNUSED 5'h1e
`define VCFC_CHROMA_AUTO_NARROW 3'h0
`define VCFC_CHROMA_AUTO_WIDE 3'h1
`define VCFC_CHROMA_FIXED1 3'h2
`define VCFC_CLAMP_MIN_LEN 8'h10
`define VCFC_CHROMA_TARGET 12'h800

// Loop time constants in milliseconds and clock rate in kHz.
`define VCFC_CLK_KHZ 100000
`define VCFC_TC_SLOW_MS 1000
`define VCFC_TC_MED_MS 500
`define VCFC_TC_FAST_MS 100

`endif

// ===== src/vcfc_clamp_pulse.v
// One clamp current pulse generator with a coded length.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`include "vcfc_defines.vh"
module vcfc_clamp_pulse (
	// Clock and reset.
	input wire core_clk,
	input wire sys_rst,
	// Control.
	input wire start,
	input wire enable,
	input wire [1:0] length_code,
	// Current source drive.
	output reg active
);
	reg [7:0] count;
	wire [7:0] length;

	// Length is 16 shifted left by the code.
	assign length = `VCFC_CLAMP_MIN_LEN << length_code;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 8'h00;
			active <= 1'b0;
		end else if (!enable) begin
			count <= 8'h00;
			active <= 1'b0;
		end else if (start) begin
			count <= length - 8'h01;
			active <= 1'b1;
		end else if (count != 8'h00) begin
			count <= count - 8'h01;
		end else begin
			active <= 1'b0;
		end
	end
endmodule

// ===== src/vcfc_regs.v
// Configuration and status register bank of the video clamp and filter block.
// Assumes decoder core flags arrive on core_clk; the output-enable pin is asynchronous.
`timescale 1ns/1ps
`include "vcfc_defines.vh"
module vcfc_regs #(
	parameter [7:0] REVISION_ID = 8'h5a,
	parameter [31:0] TC_SLOW_CYC = `VCFC_TC_SLOW_MS * `VCFC_CLK_KHZ,
	parameter [31:0] TC_MED_CYC = `VCFC_TC_MED_MS * `VCFC_CLK_KHZ,
	parameter [31:0] TC_FAST_CYC = `VCFC_TC_FAST_MS * `VCFC_CLK_KHZ,
	parameter [11:0] SCALE_HEAVY = 12'h800
) (
	// Clock and reset.
	input wire core_clk,
	input wire sys_rst,
	// Avalon-MM slave.
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Interrupt.
	output wire irq,
	// Decoder core status.
	input wire in_lock,
	input wire fsc_lock,
	input wire field_50hz,
	input wire adc_underflow,
	input wire adc_overflow,
	input wire white_peak,
	input wire color_kill,
	// Timing output drivers.
	input wire output_enable_n,
	input wire timing_output_disable,
	output wire timing_output_drive,
	// Analog clamp.
	input wire clamp_start,
	output wire fine_clamp_on,
	output wire fast_clamp_on,
	output wire current_clamp_enable,
	output wire voltage_clamp_enable,
	// Digital clamp data path.
	input wire video_quality_setting,
	input wire [11:0] adc_luma,
	input wire [11:0] adc_chroma,
	output reg [11:0] core_luma,
	output reg [11:0] core_chroma,
	output reg [11:0] clamp_correction,
	// Shaping filters.
	input wire [11:0] scaling_factor,
	output wire [4:0] luma_filter_select,
	output wire luma_filter_valid,
	output reg [2:0] chroma_filter_active
);
	reg [7:0] timing_reg;
	reg [7:0] aclamp_reg;
	reg [7:0] dclamp_hi;
	reg [7:0] dclamp_lo;
	reg [7:0] filter_reg;
	reg lost_lock;
	reg [3:0] irq_status;
	reg [3:0] irq_enable;
	reg ack;
	reg oe_meta;
	reg oe_sync;
	reg in_lock_d;
	reg fsc_lock_d;
	reg [31:0] tc_count;
	reg [11:0] next_chroma;
	reg [7:0] read_mux;
	wire req;
	wire [5:0] idx;
	wire addr_ok;
	wire wr_en;
	wire rd_en;
	wire [3:0] events;
	wire [3:0] irq_clear;
	wire lost_lock_event;
	wire timing_force;
	wire digital_clamp_mode;
	wire digital_clamp_freeze;
	wire [1:0] digital_clamp_time_constant;
	wire [11:0] digital_clamp_offset;
	wire [2:0] chroma_filter_select;
	wire [31:0] tc_limit;
	wire loop_tick;
	wire loop_hold;

	// Bus handshake: each access waits one cycle, then completes.
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack;
	assign idx = avs_address[7:2];
	assign addr_ok = avs_address[1:0] == 2'b00;
	// A write commits at the edge where the master already sees waitrequest low.
	assign wr_en = avs_write & ack & addr_ok & avs_byteenable[0];
	// Read data is registered in the wait cycle and stands through the answer cycle.
	assign rd_en = avs_read & ~ack;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// Field views of the configuration registers.
	assign timing_force = timing_reg[`VCFC_TIM_FORCE_BIT];
	assign current_clamp_enable = aclamp_reg[`VCFC_ACL_CCL_BIT];
	assign voltage_clamp_enable = aclamp_reg[`VCFC_ACL_VCL_BIT];
	assign digital_clamp_offset = {dclamp_hi[`VCFC_DCH_OFS_MSB:0], dclamp_lo};
	assign digital_clamp_freeze = dclamp_hi[`VCFC_DCH_FREEZE_BIT];
	assign digital_clamp_time_constant = dclamp_hi[`VCFC_DCH_TC_LSB+1:`VCFC_DCH_TC_LSB];
	assign digital_clamp_mode = dclamp_hi[`VCFC_DCH_MODE_BIT];
	assign luma_filter_select = filter_reg[4:0];
	assign luma_filter_valid = filter_reg[4:0] != `VCFC_LUMA_UNUSED;
	assign chroma_filter_select = filter_reg[7:`VCFC_FLT_CHROMA_LSB];

	// Register writes; the revision and status words have no write path.
	// Reserved bits outside the analog clamp and interrupt enable words are stored as written.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			timing_reg <= `VCFC_RST_TIMING;
			aclamp_reg <= `VCFC_RST_ACLAMP;
			dclamp_hi <= `VCFC_RST_DCLAMP_HI;
			dclamp_lo <= `VCFC_RST_DCLAMP_LO;
			filter_reg <= `VCFC_RST_FILTER;
			irq_enable <= 4'h0;
		end else if (wr_en) begin
			case (idx)
				`VCFC_IDX_TIMING: begin
					timing_reg <= avs_writedata[7:0];
				end
				`VCFC_IDX_ACLAMP: begin
					// Reserved top bits are kept at zero.
					aclamp_reg <= avs_writedata[7:0] & `VCFC_ACL_MASK;
				end
				`VCFC_IDX_DCLAMP_HI: begin
					dclamp_hi <= avs_writedata[7:0];
				end
				`VCFC_IDX_DCLAMP_LO: begin
					dclamp_lo <= avs_writedata[7:0];
				end
				`VCFC_IDX_FILTER: begin
					filter_reg <= avs_writedata[7:0];
				end
				`VCFC_IDX_IRQ_ENABLE: begin
					irq_enable <= avs_writedata[3:0];
				end
				default: begin
					timing_reg <= timing_reg;
				end
			endcase
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always @* begin
		read_mux = 8'h00;
		if (addr_ok) begin
			case (idx)
				`VCFC_IDX_STATUS: begin
					read_mux = {color_kill, white_peak, adc_overflow, adc_underflow,
						field_50hz, fsc_lock, lost_lock, in_lock};
				end
				`VCFC_IDX_REVISION: begin
					read_mux = REVISION_ID;
				end
				`VCFC_IDX_TIMING: begin
					read_mux = timing_reg;
				end
				`VCFC_IDX_ACLAMP: begin
					read_mux = aclamp_reg;
				end
				`VCFC_IDX_DCLAMP_HI: begin
					read_mux = dclamp_hi;
				end
				`VCFC_IDX_DCLAMP_LO: begin
					read_mux = dclamp_lo;
				end
				`VCFC_IDX_FILTER: begin
					read_mux = filter_reg;
				end
				`VCFC_IDX_IRQ_STATUS: begin
					read_mux = {4'h0, irq_status};
				end
				`VCFC_IDX_IRQ_ENABLE: begin
					read_mux = {4'h0, irq_enable};
				end
				default: begin
					read_mux = 8'h00;
				end
			endcase
		end
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_en) begin
			avs_readdata <= {24'h00_0000, read_mux};
		end
	end

	// Lost-lock flag is sticky until the status word is read; a new loss wins.
	assign lost_lock_event = in_lock_d & ~in_lock;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_lock_d <= 1'b0;
			fsc_lock_d <= 1'b0;
			lost_lock <= 1'b0;
		end else begin
			in_lock_d <= in_lock;
			fsc_lock_d <= fsc_lock;
			if (lost_lock_event) begin
				lost_lock <= 1'b1;
			end else if (rd_en && addr_ok && idx == `VCFC_IDX_STATUS) begin
				lost_lock <= 1'b0;
			end
		end
	end

	// Interrupt status: lock lost, subcarrier lock lost, underflow, overflow.
	assign events = {adc_overflow, adc_underflow, fsc_lock_d & ~fsc_lock, lost_lock_event};
	assign irq_clear = (wr_en && idx == `VCFC_IDX_IRQ_CLEAR) ? avs_writedata[3:0] : 4'h0;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status <= 4'h0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | events;
		end
	end

	assign irq = |(irq_status & irq_enable);

	// Output-enable pin synchroniser.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			oe_meta <= 1'b1;
			oe_sync <= 1'b1;
		end else begin
			oe_meta <= output_enable_n;
			oe_sync <= oe_meta;
		end
	end

	assign timing_output_drive = timing_force | (~oe_sync & ~timing_output_disable);

	// Clamp current pulses, gated by the current clamp enable.
	// A disable ends a pulse in progress; both pulses share one start strobe.
	vcfc_clamp_pulse u_fine (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(clamp_start),
		.enable(current_clamp_enable),
		.length_code(aclamp_reg[1:0]),
		.active(fine_clamp_on)
	);

	vcfc_clamp_pulse u_fast (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(clamp_start),
		.enable(current_clamp_enable),
		.length_code(aclamp_reg[3:2]),
		.active(fast_clamp_on)
	);

	// Loop update interval from the time constant field.
	assign tc_limit = (digital_clamp_time_constant == 2'b00) ? TC_SLOW_CYC :
		(digital_clamp_time_constant == 2'b01) ? TC_MED_CYC :
		(digital_clamp_time_constant == 2'b10) ? TC_FAST_CYC :
		(video_quality_setting ? TC_SLOW_CYC : TC_FAST_CYC);
	assign loop_tick = tc_count >= tc_limit - 32'h0000_0001;
	// Freeze and manual mode park the interval counter at zero.
	assign loop_hold = digital_clamp_freeze | digital_clamp_mode;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tc_count <= 32'h0000_0000;
		end else if (loop_hold || loop_tick) begin
			tc_count <= 32'h0000_0000;
		end else begin
			tc_count <= tc_count + 32'h0000_0001;
		end
	end

	// Automatic loop steps the chroma correction towards the black target.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clamp_correction <= 12'h000;
		end else if (digital_clamp_freeze) begin
			clamp_correction <= clamp_correction;
		end else if (!digital_clamp_mode && loop_tick) begin
			if (adc_chroma + clamp_correction > `VCFC_CHROMA_TARGET) begin
				clamp_correction <= clamp_correction - 12'h001;
			end else if (adc_chroma + clamp_correction < `VCFC_CHROMA_TARGET) begin
				clamp_correction <= clamp_correction + 12'h001;
			end
		end
	end

	// Offset source: manual offset or loop correction, chroma only.
	always @* begin
		next_chroma = adc_chroma + clamp_correction;
		if (digital_clamp_mode) begin
			next_chroma = adc_chroma + digital_clamp_offset;
		end
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_luma <= 12'h000;
			core_chroma <= 12'h000;
		end else begin
			core_luma <= adc_luma;
			core_chroma <= next_chroma;
		end
	end

	// Chroma filter: automatic codes pick by scaling factor.
	// The choice is registered, so a new scaling factor shows one cycle later.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chroma_filter_active <= `VCFC_CHROMA_AUTO_NARROW;
		end else if (chroma_filter_select == `VCFC_CHROMA_AUTO_NARROW ||
			chroma_filter_select == `VCFC_CHROMA_AUTO_WIDE) begin
			if (scaling_factor >= SCALE_HEAVY) begin
				chroma_filter_active <= `VCFC_CHROMA_FIXED1;
			end else begin
				chroma_filter_active <= chroma_filter_select;
			end
		end else begin
			chroma_filter_active <= chroma_filter_select;
		end
	end
endmodule

// ===== bench/vcfc_regs_sva.sv
// Port assertions for the clamp and filter register bank.
// Bound to vcfc_regs; one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module vcfc_regs_sva (
	// Clock and reset.
	input wire core_clk,
	input wire sys_rst,
	// Watched ports.
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire clamp_start,
	input wire fine_clamp_on,
	input wire fast_clamp_on,
	input wire current_clamp_enable,
	input wire [11:0] adc_luma,
	input wire [11:0] core_luma,
	input wire [11:0] clamp_correction,
	input wire [4:0] luma_filter_select,
	input wire luma_filter_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_on16(x);
		x[*8] ##1 x[*8];
	endsequence
	property p_wait;
		s_req |=> !avs_waitrequest;
	endproperty
	property p_rdz;
		avs_readdata[31:8] == 24'h0;
	endproperty
	property p_start;
		clamp_start && current_clamp_enable && !fine_clamp_on |=> fine_clamp_on;
	endproperty
	property p_fine;
		$rose(fine_clamp_on) |-> s_on16(fine_clamp_on);
	endproperty
	property p_fast;
		$rose(fast_clamp_on) |-> s_on16(fast_clamp_on);
	endproperty
	property p_en;
		!current_clamp_enable |=> !fine_clamp_on && !fast_clamp_on;
	endproperty
	property p_luma;
		core_luma == $past(adc_luma);
	endproperty
	property p_vald;
		luma_filter_valid == (luma_filter_select != 5'h1e);
	endproperty
	property p_corr;
		clamp_correction != $past(clamp_correction) |->
			clamp_correction == $past(clamp_correction) + 12'h1 || clamp_correction + 12'h1 == $past(clamp_correction);
	endproperty
	a_wait: assert property (p_wait) else $error("Bus answer not after one wait cycle.");
	a_rdz: assert property (p_rdz) else $error("Upper read data not zero.");
	a_start: assert property (p_start) else $error("Fine clamp did not start.");
	a_fine: assert property (p_fine) else $error("Fine clamp pulse too short.");
	a_fast: assert property (p_fast) else $error("Fast clamp pulse too short.");
	a_en: assert property (p_en) else $error("Clamp on while disabled.");
	a_luma: assert property (p_luma) else $error("Luma not passed through.");
	a_vald: assert property (p_vald) else $error("Luma valid flag wrong.");
	a_corr: assert property (p_corr) else $error("Correction step not one.");
endmodule
bind vcfc_regs vcfc_regs_sva i_vcfc_regs_sva (.core_clk(core_clk), .sys_rst(sys_rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.clamp_start(clamp_start), .fine_clamp_on(fine_clamp_on), .fast_clamp_on(fast_clamp_on),
	.current_clamp_enable(current_clamp_enable), .adc_luma(adc_luma), .core_luma(core_luma),
	.clamp_correction(clamp_correction), .luma_filter_select(luma_filter_select),
	.luma_filter_valid(luma_filter_valid));

// ===== bench/test_video_clamp_filter_config.sv
// Self-checking bench of the clamp and filter register bank.
// Drives vcfc_regs directly over its Avalon-MM slave and core ports.
`timescale 1ns/1ps
module test_video_clamp_filter_config;
	// Clock, reset and bus.
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] avs_address = 8'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire irq;
	// Core side.
	reg in_lock = 1'b1;
	reg fsc_lock = 1'b1;
	reg field_50hz = 1'b1;
	reg white_peak = 1'b1;
	reg adc_underflow = 1'b0;
	reg adc_overflow = 1'b0;
	reg color_kill = 1'b0;
	reg video_quality_setting = 1'b0;
	reg [3:0] avs_byteenable = 4'hf;
	reg output_enable_n = 1'b1;
	reg timing_output_disable = 1'b1;
	reg clamp_start = 1'b0;
	reg [11:0] adc_luma = 12'h0;
	reg [11:0] adc_chroma = 12'h0;
	reg [11:0] scaling_factor = 12'h100;
	wire timing_output_drive, fine_clamp_on, fast_clamp_on, current_clamp_enable, voltage_clamp_enable;
	wire [11:0] core_luma, core_chroma, clamp_correction;
	wire [4:0] luma_filter_select;
	wire luma_filter_valid;
	wire [2:0] chroma_filter_active;
	integer fail_count = 0;
	integer num_checks = 0;
	integer i;
	reg [7:0] q;
	reg [11:0] c;
	// The revision value 8'h3c is arbitrary.
	vcfc_regs #(.REVISION_ID(8'h3c), .TC_SLOW_CYC(32'd20), .TC_MED_CYC(32'd10), .TC_FAST_CYC(32'd4),
		.SCALE_HEAVY(12'h800)) i_vcfc_regs (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .in_lock(in_lock),
		.fsc_lock(fsc_lock), .field_50hz(field_50hz), .adc_underflow(adc_underflow), .adc_overflow(adc_overflow),
		.white_peak(white_peak), .color_kill(color_kill), .output_enable_n(output_enable_n),
		.timing_output_disable(timing_output_disable), .timing_output_drive(timing_output_drive),
		.clamp_start(clamp_start), .fine_clamp_on(fine_clamp_on), .fast_clamp_on(fast_clamp_on),
		.current_clamp_enable(current_clamp_enable), .voltage_clamp_enable(voltage_clamp_enable),
		.video_quality_setting(video_quality_setting), .adc_luma(adc_luma), .adc_chroma(adc_chroma),
		.core_luma(core_luma),
		.core_chroma(core_chroma), .clamp_correction(clamp_correction), .scaling_factor(scaling_factor),
		.luma_filter_select(luma_filter_select), .luma_filter_valid(luma_filter_valid),
		.chroma_filter_active(chroma_filter_active));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task results;
		begin
			if (fail_count == 0 && num_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] s);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task bus(input rd, input [7:0] a, input [7:0] d);
		integer n;
		begin
			@(posedge core_clk);
			avs_address <= a;
			avs_read <= rd;
			avs_write <= !rd;
			avs_writedata <= {24'h0, d};
			n = 0;
			do begin
				@(posedge core_clk);
				n = n + 1;
			end while (avs_waitrequest !== 1'b0 && n < 50);
			if (avs_waitrequest !== 1'b0) begin
				fail_count = fail_count + 1;
				results;
			end else begin
				q = avs_readdata[7:0];
				avs_read <= 1'b0;
				avs_write <= 1'b0;
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		bus(1'b0, a, d);
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			bus(1'b1, a, 8'h00);
			chk("readdata", e, q);
		end
	endtask
	task look(input [8*8:1] nm, input [31:0] e);
		begin
			@(negedge core_clk);
			if (nm == "drive")
				chk(nm, e, timing_output_drive);
			else
				chk(nm, e, irq);
		end
	endtask
	task t_regs;
		begin
			rd(8'h4c, 8'h45);
			rd(8'h44, 8'h3c);
			wr(8'h44, 8'hff);
			rd(8'h44, 8'h3c);
			rd(8'h7c, 8'h00);
			avs_byteenable <= 4'he;
			wr(8'h58, 8'h77);
			avs_byteenable <= 4'hf;
			rd(8'h58, 8'h00);
			wr(8'h40, 8'hff);
			rd(8'h40, 8'h4d);
		end
	endtask
	task t_lock;
		begin
			@(posedge core_clk);
			in_lock <= 1'b0;
			@(posedge core_clk);
			in_lock <= 1'b1;
			look("irq", 1'b0);
			rd(8'h40, 8'h4f);
			rd(8'h40, 8'h4d);
			wr(8'h84, 8'h01);
			look("irq", 1'b1);
			rd(8'h80, 8'h01);
			wr(8'h88, 8'h01);
			look("irq", 1'b0);
		end
	endtask
	task t_force;
		begin
			look("drive", 1'b0);
			wr(8'h4c, 8'h47);
			look("drive", 1'b1);
			wr(8'h4c, 8'h45);
			look("drive", 1'b0);
			@(posedge core_clk);
			output_enable_n <= 1'b0;
			timing_output_disable <= 1'b0;
			repeat (4) @(posedge core_clk);
			look("drive", 1'b1);
		end
	endtask
	task pulse(input [7:0] ef, input [7:0] es);
		integer f, s;
		begin
			@(posedge core_clk);
			clamp_start <= 1'b1;
			@(posedge core_clk);
			clamp_start <= 1'b0;
			f = 0;
			s = 0;
			repeat (200) begin
				@(negedge core_clk);
				f = f + fine_clamp_on;
				s = s + fast_clamp_on;
			end
			chk("fine", ef, f);
			chk("fast", es, s);
		end
	endtask
	task t_clamp;
		begin
			wr(8'h50, 8'h13);
			pulse(8'd128, 8'd16);
			wr(8'h50, 8'h26);
			@(negedge core_clk);
			chk("vclamp", 1'b1, voltage_clamp_enable);
			pulse(8'd0, 8'd0);
			wr(8'h50, 8'h16);
			@(negedge core_clk);
			chk("vclamp", 1'b0, voltage_clamp_enable);
			pulse(8'd64, 8'd32);
		end
	endtask
	task t_dclamp;
		begin
			@(posedge core_clk);
			adc_chroma <= 12'h100;
			adc_luma <= 12'h055;
			wr(8'h54, 8'h81);
			wr(8'h58, 8'h23);
			repeat (2) @(negedge core_clk);
			chk("chroma", 12'h223, core_chroma);
			chk("luma", 12'h055, core_luma);
			wr(8'h54, 8'h10);
			@(negedge core_clk);
			c = clamp_correction;
			repeat (60) @(negedge core_clk);
			chk("corr", c, clamp_correction);
			rate(8'h00, 12'd1);
			rate(8'h20, 12'd3);
			rate(8'h40, 12'd9);
			@(posedge core_clk);
			video_quality_setting <= 1'b1;
			rate(8'h60, 12'd1);
			@(posedge core_clk);
			video_quality_setting <= 1'b0;
			rate(8'h60, 12'd9);
		end
	endtask
	task rate(input [7:0] v, input [11:0] n);
		begin
			wr(8'h54, v);
			@(negedge core_clk);
			c = clamp_correction;
			repeat (38) @(negedge core_clk);
			chk("corr", c + n, clamp_correction);
			wr(8'h54, 8'h10);
		end
	endtask
	task t_flags;
		begin
			@(posedge core_clk);
			color_kill <= 1'b1;
			white_peak <= 1'b0;
			field_50hz <= 1'b0;
			fsc_lock <= 1'b0;
			adc_underflow <= 1'b1;
			adc_overflow <= 1'b1;
			@(posedge core_clk);
			adc_underflow <= 1'b0;
			adc_overflow <= 1'b0;
			rd(8'h40, 8'h81);
			rd(8'h80, 8'h0e);
			look("irq", 1'b0);
			wr(8'h84, 8'h08);
			look("irq", 1'b1);
			@(posedge core_clk);
			adc_overflow <= 1'b1;
			wr(8'h88, 8'h0e);
			look("irq", 1'b1);
			@(posedge core_clk);
			adc_overflow <= 1'b0;
			wr(8'h88, 8'h0e);
			look("irq", 1'b0);
			rd(8'h80, 8'h00);
			@(posedge core_clk);
			color_kill <= 1'b0;
			white_peak <= 1'b1;
			field_50hz <= 1'b1;
			fsc_lock <= 1'b1;
		end
	endtask
	task t_filter;
		begin
			for (i = 0; i < 32; i = i + 1) begin
				wr(8'h5c, {3'h7, i[4:0]});
				repeat (2) @(negedge core_clk);
				chk("luma", i[4:0], luma_filter_select);
				chk("valid", i != 30, luma_filter_valid);
				chk("cfilt", 3'h7, chroma_filter_active);
			end
			wr(8'h5c, 8'h00);
			repeat (2) @(negedge core_clk);
			chk("cfilt", 3'h0, chroma_filter_active);
			wr(8'h5c, 8'h20);
			repeat (2) @(negedge core_clk);
			chk("cfilt", 3'h1, chroma_filter_active);
			@(posedge core_clk);
			scaling_factor <= 12'h900;
			repeat (3) @(negedge core_clk);
			chk("cfilt", 3'h2, chroma_filter_active);
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_lock;
		t_flags;
		t_force;
		t_clamp;
		t_dclamp;
		t_filter;
		results;
	end
endmodule
